// [mcd_pkg.sv]
`default_nettype none
package mcd_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // Instruction width and driver count
  localparam int INSTR_W = 16;
  localparam int DRV_NUM = 12;
  localparam int AMP_NUM = 4;
  localparam int DRAM_AW = 6;
  localparam int SRC_W = 5;

  // Opcode patterns
  localparam logic [14:0] OPC_FREEWHEEL = 15'h1AC8;
  localparam logic [14:0] OPC_HOST_IRQ = 15'h1AC9;
  localparam logic [11:0] OPC_AMP_GAIN = 12'h353;
  localparam logic [9:0] OPC_SINGLE_DRV = 10'h0D2;
  localparam logic [9:0] OPC_SHORTCUT = 10'h0D1;
  localparam logic [12:0] OPC_COMPENSATE = 13'h06AA;
  localparam logic [1:0] OPC_STORE_HI = 2'h2;
  localparam logic [1:0] OPC_STORE_LO = 2'h1;

  // Output actions
  localparam logic [1:0] ACT_KEEP = 2'h0;
  localparam logic [1:0] ACT_OFF = 2'h1;
  localparam logic [1:0] ACT_ON = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Driver select codes used by the freewheel pairing, and the last valid select
  localparam logic [3:0] SEL_HIGH1 = 4'h0;
  localparam logic [3:0] SEL_HIGH2 = 4'h1;
  localparam logic [3:0] SEL_HIGH3 = 4'h2;
  localparam logic [3:0] SEL_HIGH4 = 4'h3;
  localparam logic [3:0] SEL_HIGH5 = 4'h4;
  localparam logic [3:0] SEL_LOW4 = 4'h8;
  localparam logic [3:0] SEL_LOW5 = 4'h9;
  localparam logic [3:0] SEL_LOW6 = 4'hA;
  localparam logic [3:0] SEL_LOW7 = 4'hB;
  localparam logic [3:0] SEL_LAST = 4'hB;

  // Gain codes
  localparam logic [1:0] GAIN_5P8 = 2'h0;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_DRV_GRANT = 8'h00;
  localparam logic [7:0] OFS_CUR_GRANT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_DRV_STATE = 8'h10;
  localparam logic [7:0] OFS_AMP_STATE = 8'h14;

  // Interrupt status bits
  localparam int EV_NUM = 3;
  localparam int EV_REFUSED = 0;
  localparam int EV_STORED = 1;
  localparam int EV_PIN = 2;

  // Reset values
  localparam logic [DRV_NUM-1:0] DRV_GRANT_RST = 12'h000;
  localparam logic [AMP_NUM-1:0] CUR_GRANT_RST = 4'h0;
  localparam logic [EV_NUM-1:0] IRQ_MASK_RST = 3'h0;

  // Data RAM write
  typedef struct packed {
    logic we;
    logic [DRAM_AW-1:0] addr;
    logic [INSTR_W-1:0] data;
  } mcd_dram_wr_s;

  // Current measurement block settings
  typedef struct packed {
    logic [AMP_NUM-1:0][1:0] gain;
    logic [AMP_NUM-1:0] comp;
  } mcd_amp_state_s;

endpackage : mcd_pkg
`default_nettype wire

// [mcd_driver_set.sv]
// Operation
// - Freewheel opcode decoded, bit 0 selects auto
// - Freewheel starts manual after reset
// - Auto freewheel partner drives the inverse of the first shortcut output
// - Driver instructions act only on granted outputs
// - Two-bit gain code, reset gain 5.8
// - Amplifier select picks core and channel
// - Gain and compensation need current block grant
// - Gain opcode, gain bits 3:2, select 1:0
// - Interrupt pin follows bit 0, resets high
// - Four-bit driver select, 1100 undefined
// - Actions keep, off, on, invert
// - Single driver opcode, select 5:2, action 1:0
// - Compensation enable per block, all off after reset
// - Compensation opcode, enable bit 2, target 1:0
// - Store writes source register into data RAM
// - Indexed flag adds address base to address
// - Store opcode, flag 13, source, address fields
// - Shortcut opcode applies three actions to shortcuts
`default_nettype none
module mcd_driver_set
  import mcd_pkg::*;
#(
  parameter int DRAM_ADDR_W = DRAM_AW
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Instruction stream
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  output logic instr_stall_o,
  // Shortcut definitions and address base
  input wire logic [3:0] first_shortcut_output_i,
  input wire logic [3:0] second_shortcut_output_i,
  input wire logic [3:0] third_shortcut_output_i,
  input wire logic [DRAM_ADDR_W-1:0] address_base_i,
  // Source register read
  output logic [SRC_W-1:0] source_register_field_o,
  input wire logic [INSTR_W-1:0] source_data_i,
  // Data RAM write
  output mcd_dram_wr_s dram_wr_o,
  // Pre-driver and current block outputs
  output logic [DRV_NUM-1:0] driver_on_o,
  output mcd_amp_state_s amp_state_o,
  output logic host_interrupt_pin_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (DRAM_ADDR_W != DRAM_AW) begin : g_bad_width
    $error("Data RAM address width must be six");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic apply_action(input logic [1:0] act,
                                        input logic cur);
    logic res;
    res = cur;
    unique case (act)
      ACT_KEEP: res = cur;
      ACT_OFF: res = 1'b0;
      ACT_ON: res = 1'b1;
      ACT_TOGGLE: res = ~cur;
    endcase
    return res;
  endfunction : apply_action

  function automatic logic [4:0] freewheel_pair(input logic [3:0] sc);
    logic [4:0] res;
    res = 5'h00;
    case (sc)
      SEL_HIGH1: res = {1'b1, SEL_LOW5};
      SEL_HIGH2: res = {1'b1, SEL_LOW6};
      SEL_HIGH3: res = {1'b1, SEL_LOW7};
      SEL_HIGH4: res = {1'b1, SEL_HIGH5};
      SEL_HIGH5: res = {1'b1, SEL_LOW4};
      default: res = 5'h00;
    endcase
    return res;
  endfunction : freewheel_pair

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [DRV_NUM-1:0] drv_grant_reg;
  logic [AMP_NUM-1:0] cur_grant_reg;
  logic [EV_NUM-1:0] irq_status_reg;
  logic [EV_NUM-1:0] irq_mask_reg;
  logic [DRV_NUM-1:0] drv_state_reg;
  logic [DRV_NUM-1:0] driver_on_reg;
  logic freewheel_auto_flag_reg;
  logic host_pin_reg;
  mcd_amp_state_s amp_reg;
  mcd_dram_wr_s dram_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic is_freewheel;
  logic is_host_irq;
  logic is_gain;
  logic is_single;
  logic is_shortcut;
  logic is_comp;
  logic is_store;

  always_comb begin
    is_freewheel = instr_valid_i && instr_i[15:1] == OPC_FREEWHEEL;
    is_host_irq = instr_valid_i && instr_i[15:1] == OPC_HOST_IRQ;
    is_gain = instr_valid_i && instr_i[15:4] == OPC_AMP_GAIN;
    is_single = instr_valid_i && instr_i[15:6] == OPC_SINGLE_DRV;
    is_shortcut = instr_valid_i && instr_i[15:6] == OPC_SHORTCUT;
    is_comp = instr_valid_i && instr_i[15:3] == OPC_COMPENSATE;
    is_store = instr_valid_i && instr_i[15:14] == OPC_STORE_HI
               && instr_i[1:0] == OPC_STORE_LO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access checks
  logic [4:0] fw_pair;
  logic fw_ok;
  logic [3:0] single_sel;
  logic single_ok;
  logic [2:0][3:0] sc_sel;
  logic [2:0][1:0] sc_act;
  logic shortcut_ok;
  logic gain_ok;
  logic comp_ok;
  logic refused;

  always_comb begin
    fw_pair = freewheel_pair(first_shortcut_output_i);
    fw_ok = !fw_pair[4] || drv_grant_reg[fw_pair[3:0]];
    single_sel = instr_i[5:2];
    single_ok = single_sel <= SEL_LAST
                && drv_grant_reg[single_sel];
    sc_sel[0] = first_shortcut_output_i;
    sc_sel[1] = second_shortcut_output_i;
    sc_sel[2] = third_shortcut_output_i;
    sc_act[0] = instr_i[5:4];
    sc_act[1] = instr_i[3:2];
    sc_act[2] = instr_i[1:0];
    shortcut_ok = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (sc_act[i] != ACT_KEEP
          && (sc_sel[i] > SEL_LAST || !drv_grant_reg[sc_sel[i]])) begin
        shortcut_ok = 1'b0;
      end
    end
    gain_ok = cur_grant_reg[instr_i[1:0]];
    comp_ok = cur_grant_reg[instr_i[1:0]];
    refused = (is_freewheel && !fw_ok) || (is_single && !single_ok)
              || (is_shortcut && !shortcut_ok) || (is_gain && !gain_ok)
              || (is_comp && !comp_ok);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Never stalls
  assign instr_stall_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Freewheel mode
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      freewheel_auto_flag_reg <= 1'b0;
    end else if (is_freewheel && fw_ok) begin
      freewheel_auto_flag_reg <= instr_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver states
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      drv_state_reg <= '0;
    end else if (is_single && single_ok) begin
      drv_state_reg[single_sel] <= apply_action(instr_i[1:0],
                                   drv_state_reg[single_sel]);
    end else if (is_shortcut && shortcut_ok) begin
      for (int i = 0; i < 3; i++) begin
        if (sc_act[i] != ACT_KEEP) begin
          drv_state_reg[sc_sel[i]] <= apply_action(sc_act[i],
                                      drv_state_reg[sc_sel[i]]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive with automatic freewheel
  logic [DRV_NUM-1:0] drv_eff;

  always_comb begin
    drv_eff = drv_state_reg & drv_grant_reg;
    if (freewheel_auto_flag_reg && fw_pair[4]
        && drv_grant_reg[fw_pair[3:0]]) begin
      drv_eff[fw_pair[3:0]] =
        ~drv_state_reg[first_shortcut_output_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      driver_on_reg <= '0;
    end else begin
      driver_on_reg <= drv_eff;
    end
  end

  assign driver_on_o = driver_on_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Amplifier gain and offset compensation
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < AMP_NUM; i++) begin
        amp_reg.gain[i] <= GAIN_5P8;
      end
      amp_reg.comp <= '0;
    end else if (is_gain && gain_ok) begin
      amp_reg.gain[instr_i[1:0]] <= instr_i[3:2];
    end else if (is_comp && comp_ok) begin
      amp_reg.comp[instr_i[1:0]] <= instr_i[2];
    end
  end

  assign amp_state_o = amp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Host interrupt pin
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      host_pin_reg <= 1'b1;
    end else if (is_host_irq) begin
      host_pin_reg <= instr_i[0];
    end
  end

  assign host_interrupt_pin_o = host_pin_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Store to data RAM
  assign source_register_field_o = instr_i[12:8];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dram_reg <= '0;
    end else begin
      dram_reg.we <= is_store;
      if (is_store) begin
        dram_reg.data <= source_data_i;
        if (instr_i[13]) begin
          dram_reg.addr <= instr_i[7:2] + address_base_i;
        end else begin
          dram_reg.addr <= instr_i[7:2];
        end
      end
    end
  end

  assign dram_wr_o = dram_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic bus_req;
  logic bus_wr;
  logic [31:0] wmask;

  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    bus_wr = bus_req && wb_we_i;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      drv_grant_reg <= DRV_GRANT_RST;
      cur_grant_reg <= CUR_GRANT_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (bus_wr) begin
      case (wb_adr_i)
        OFS_DRV_GRANT: drv_grant_reg <= (drv_grant_reg & ~wmask[11:0])
                                        | (wb_dat_i[11:0] & wmask[11:0]);
        OFS_CUR_GRANT: cur_grant_reg <= (cur_grant_reg & ~wmask[3:0])
                                        | (wb_dat_i[3:0] & wmask[3:0]);
        OFS_IRQ_MASK: irq_mask_reg <= (irq_mask_reg & ~wmask[2:0])
                                      | (wb_dat_i[2:0] & wmask[2:0]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_DRV_GRANT: rdata_reg <= {20'h00000, drv_grant_reg};
        OFS_CUR_GRANT: rdata_reg <= {28'h0000000, cur_grant_reg};
        OFS_IRQ_STATUS: rdata_reg <= {29'h00000000, irq_status_reg};
        OFS_IRQ_MASK: rdata_reg <= {29'h00000000, irq_mask_reg};
        OFS_DRV_STATE: rdata_reg <= {18'h00000, host_pin_reg,
                                     freewheel_auto_flag_reg, driver_on_reg};
        OFS_AMP_STATE: rdata_reg <= {20'h00000, amp_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end

  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  logic [EV_NUM-1:0] ev_set;
  logic [EV_NUM-1:0] ev_clr;

  always_comb begin
    ev_set = '0;
    ev_set[EV_REFUSED] = refused;
    ev_set[EV_STORED] = is_store;
    ev_set[EV_PIN] = is_host_irq && instr_i[0] != host_pin_reg;
    ev_clr = '0;
    if (bus_wr && wb_adr_i == OFS_IRQ_STATUS && wb_sel_i[0]) begin
      ev_clr = wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~ev_clr) | ev_set;
    end
  end

  logic irq_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  assign irq_o = irq_reg;

endmodule : mcd_driver_set
`default_nettype wire

// [mcd_partner.sv]
`default_nettype none
module mcd_partner
  import mcd_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register file and data RAM side
  input wire logic [SRC_W-1:0] source_register_field_i,
  output logic [INSTR_W-1:0] source_data_o,
  input wire mcd_dram_wr_s dram_wr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [INSTR_W-1:0] mem [64];

  // Each source register holds a pattern built from its number
  assign source_data_o = {3'h5, source_register_field_i, 3'h2,
                          source_register_field_i};

  // Data RAM line captured on the write pulse
  always_ff @(posedge clk_i) begin
    if (dram_wr_i.we) begin
      mem[dram_wr_i.addr] <= dram_wr_i.data;
    end
  end
endmodule : mcd_partner
`default_nettype wire

// [mcd_driver_set_sva.sv]
`default_nettype none
module mcd_driver_set_sva
  import mcd_pkg::*;
#(
  parameter int DRAM_ADDR_W = DRAM_AW
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Instruction side
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic instr_stall_o,
  input wire logic [DRAM_ADDR_W-1:0] address_base_i,
  input wire logic [INSTR_W-1:0] source_data_i,
  // Outputs
  input wire mcd_dram_wr_s dram_wr_o,
  input wire logic [DRV_NUM-1:0] driver_on_o,
  input wire mcd_amp_state_s amp_state_o,
  input wire logic host_interrupt_pin_o,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic store_op;
  logic pin_op;
  logic [DRAM_AW-1:0] idx_addr;

  assign store_op = instr_valid_i && instr_i[15:14] == OPC_STORE_HI &&
                    instr_i[1:0] == OPC_STORE_LO;
  assign pin_op = instr_valid_i && instr_i[15:1] == OPC_HOST_IRQ;
  assign idx_addr = instr_i[7:2] + DRAM_AW'(address_base_i);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////
  chk_never_stall: assert property (!instr_stall_o)
    else $error("instruction stall raised");
  chk_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_store_data: assert property (
    store_op |=> dram_wr_o.we && dram_wr_o.data == $past(source_data_i))
    else $error("store data wrong");
  chk_store_direct: assert property (
    store_op && !instr_i[13] |=> dram_wr_o.addr == $past(instr_i[7:2]))
    else $error("direct store address wrong");
  chk_store_indexed: assert property (
    store_op && instr_i[13] |=> dram_wr_o.addr == $past(idx_addr))
    else $error("indexed store address wrong");
  chk_we_pulse: assert property (!store_op |=> !dram_wr_o.we)
    else $error("write pulse without store");
  chk_pin_level: assert property (
    pin_op |=> host_interrupt_pin_o == $past(instr_i[0]))
    else $error("host pin level wrong");
  chk_pin_hold: assert property (
    !pin_op |=> $stable(host_interrupt_pin_o))
    else $error("host pin changed without instruction");
  chk_undef_select: assert property (
    instr_valid_i && instr_i[15:6] == OPC_SINGLE_DRV &&
    instr_i[5:2] > SEL_LAST |=> ##1 $stable(driver_on_o))
    else $error("undefined select changed outputs");
  chk_reset_state: assert property (disable iff (1'b0)
    reset_i |=> host_interrupt_pin_o && driver_on_o == '0 &&
    amp_state_o == '0)
    else $error("reset state wrong");
endmodule : mcd_driver_set_sva

bind mcd_driver_set mcd_driver_set_sva #(.DRAM_ADDR_W(DRAM_ADDR_W))
  u_mcd_driver_set_sva (.clk_i(clk_i), .reset_i(reset_i),
  .instr_i(instr_i), .instr_valid_i(instr_valid_i),
  .instr_stall_o(instr_stall_o), .address_base_i(address_base_i),
  .source_data_i(source_data_i), .dram_wr_o(dram_wr_o),
  .driver_on_o(driver_on_o), .amp_state_o(amp_state_o),
  .host_interrupt_pin_o(host_interrupt_pin_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// [mcd_driver_set_test.sv]
`default_nettype none
module mcd_driver_set_test
  import mcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic reset_i;
  logic [INSTR_W-1:0] instr_i;
  logic instr_valid_i;
  logic instr_stall_o;
  logic [3:0] first_shortcut_output_i;
  logic [3:0] second_shortcut_output_i;
  logic [3:0] third_shortcut_output_i;
  logic [DRAM_AW-1:0] address_base_i;
  logic [SRC_W-1:0] source_register_field_o;
  logic [INSTR_W-1:0] source_data_i;
  mcd_dram_wr_s dram_wr_o;
  logic [DRV_NUM-1:0] driver_on_o;
  mcd_amp_state_s amp_state_o;
  logic host_interrupt_pin_o;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [31:0] r;
  int comparisons = 0;
  int miscompares = 0;
  int cycles = 0;

  mcd_driver_set u_mcd_driver_set (.clk_i(clk_i), .reset_i(reset_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .instr_stall_o(instr_stall_o),
    .first_shortcut_output_i(first_shortcut_output_i),
    .second_shortcut_output_i(second_shortcut_output_i),
    .third_shortcut_output_i(third_shortcut_output_i),
    .address_base_i(address_base_i),
    .source_register_field_o(source_register_field_o),
    .source_data_i(source_data_i), .dram_wr_o(dram_wr_o),
    .driver_on_o(driver_on_o), .amp_state_o(amp_state_o),
    .host_interrupt_pin_o(host_interrupt_pin_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o));
  mcd_partner u_mcd_partner (.clk_i(clk_i),
    .source_register_field_i(source_register_field_o),
    .source_data_o(source_data_i), .dram_wr_i(dram_wr_o));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // Classic single bus cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    #1;
  endtask : wb

  // One instruction, then wait for the pins to follow
  task automatic run(input logic [INSTR_W-1:0] w);
    @(posedge clk_i);
    instr_i <= w;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(32'(host_interrupt_pin_o), 32'h1);
    check(32'(amp_state_o), 32'h0);
    wb(1'b0, OFS_DRV_STATE, 32'h0, r);
    check(r, 32'h2000);
    wb(1'b0, OFS_AMP_STATE, 32'h0, r);
    check(r, 32'h0);
    wb(1'b0, 8'h40, 32'h0, r);
    check(r, 32'h0);
  endtask : t_reset

  task automatic t_single();
    logic [1:0] act [5] = '{ACT_ON, ACT_KEEP, ACT_TOGGLE, ACT_TOGGLE,
                            ACT_OFF};
    logic [4:0] bitv = 5'h0B;
    wb(1'b1, OFS_DRV_GRANT, 32'hFFF, r);
    for (int s = 0; s < DRV_NUM; s++) begin
      for (int k = 0; k < 5; k++) begin
        run({OPC_SINGLE_DRV, 4'(s), act[k]});
        check(32'(driver_on_o), 32'(bitv[k]) << s);
      end
    end
  endtask : t_single

  task automatic t_refuse();
    wb(1'b1, OFS_IRQ_STATUS, 32'h7, r);
    wb(1'b1, OFS_IRQ_MASK, 32'h1, r);
    run({OPC_SINGLE_DRV, 4'hC, ACT_ON});
    check(32'(driver_on_o), 32'h0);
    check(32'(irq_o), 32'h1);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, r);
    check(r, 32'h1);
    wb(1'b1, OFS_IRQ_STATUS, 32'h1, r);
    check(32'(irq_o), 32'h0);
    wb(1'b1, OFS_DRV_GRANT, 32'hFFD, r);
    run({OPC_SINGLE_DRV, 4'h1, ACT_ON});
    check(32'(driver_on_o), 32'h0);
    check(32'(irq_o), 32'h1);
    wb(1'b1, OFS_IRQ_MASK, 32'h0, r);
    check(32'(irq_o), 32'h0);
    check(32'(instr_stall_o), 32'h0);
  endtask : t_refuse

  task automatic t_shortcut();
    wb(1'b1, OFS_DRV_GRANT, 32'hFFF, r);
    run({OPC_SHORTCUT, ACT_ON, ACT_ON, ACT_KEEP});
    check(32'(driver_on_o), 32'h022);
    run({OPC_SHORTCUT, ACT_TOGGLE, ACT_KEEP, ACT_ON});
    check(32'(driver_on_o), 32'h820);
    wb(1'b1, OFS_DRV_GRANT, 32'h7FF, r);
    run({OPC_SHORTCUT, ACT_ON, ACT_OFF, ACT_OFF});
    check(32'(driver_on_o), 32'h020);
    wb(1'b1, OFS_DRV_GRANT, 32'hFFF, r);
    check(32'(driver_on_o), 32'h820);
  endtask : t_shortcut

  task automatic t_amp();
    wb(1'b1, OFS_CUR_GRANT, 32'hF, r);
    for (int s = 0; s < AMP_NUM; s++) begin
      run({OPC_AMP_GAIN, 2'(3 - s), 2'(s)});
      check(32'(amp_state_o.gain[s]), 32'(3 - s));
    end
    run({OPC_COMPENSATE, 1'b1, 2'h2});
    run({OPC_COMPENSATE, 1'b1, 2'h0});
    check(32'(amp_state_o.comp), 32'h5);
    wb(1'b1, OFS_CUR_GRANT, 32'hB, r);
    run({OPC_COMPENSATE, 1'b0, 2'h2});
    run({OPC_AMP_GAIN, 2'h3, 2'h2});
    run({OPC_COMPENSATE, 1'b0, 2'h0});
    wb(1'b0, OFS_AMP_STATE, 32'h0, r);
    check(r, 32'h1B4);
  endtask : t_amp

  task automatic t_pin_store();
    wb(1'b1, OFS_IRQ_STATUS, 32'h7, r);
    run({OPC_HOST_IRQ, 1'b0});
    check(32'(host_interrupt_pin_o), 32'h0);
    run({OPC_HOST_IRQ, 1'b1});
    check(32'(host_interrupt_pin_o), 32'h1);
    run({2'h2, 1'b0, 5'h03, 6'h3E, 2'h1});
    check(32'(u_mcd_partner.mem[62]), 32'hA343);
    run({2'h2, 1'b1, 5'h1F, 6'h3D, 2'h1});
    check(32'(u_mcd_partner.mem[2]), 32'hBF5F);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, r);
    check(r, 32'h6);
  endtask : t_pin_store

  task automatic t_freewheel();
    logic [3:0] pair [5] = '{SEL_LOW5, SEL_LOW6, SEL_LOW7, SEL_HIGH5,
                             SEL_LOW4};
    run({OPC_FREEWHEEL, 1'b1});
    wb(1'b0, OFS_DRV_STATE, 32'h0, r);
    check(32'(r[12]), 32'h1);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      first_shortcut_output_i <= 4'(i);
      run({OPC_SHORTCUT, ACT_ON, ACT_KEEP, ACT_KEEP});
      check(32'(driver_on_o[pair[i]]), 32'h0);
      run({OPC_SHORTCUT, ACT_OFF, ACT_KEEP, ACT_KEEP});
      check(32'(driver_on_o[pair[i]]), 32'h1);
    end
    run({OPC_FREEWHEEL, 1'b0});
    wb(1'b0, OFS_DRV_STATE, 32'h0, r);
    check(32'(r[12]), 32'h0);
  endtask : t_freewheel

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    reset_i = 1'b1;
    instr_i = 16'h0000;
    instr_valid_i = 1'b0;
    first_shortcut_output_i = 4'h1;
    second_shortcut_output_i = 4'h5;
    third_shortcut_output_i = 4'hB;
    address_base_i = 6'h05;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_single();
    t_refuse();
    t_shortcut();
    t_amp();
    t_pin_store();
    t_freewheel();
    results();
  end
endmodule : mcd_driver_set_test
`default_nettype wire
